// file: verilog/aluim_defines.vh
// Constants for the ALU operand input selection block and its register port.
// Assumes inclusion by bare name from the design files; holds definitions only.
//
// Overview of operation
// - A operand picks destination, source, PC buffer or bus register by two-bit field.
// - B select 00 increment constant, 01 vector/offset, 10 source, 11 bus register.
// - B select 00: bits 3:0 increment constant, 7:4 zero, 15:8 increment extension.
// - B select 01: bits 7:1 vector mux, extension high, bits 8,11 gated by select bit0.
// - Function field 7 with byte move forces B high byte to increment extension bit.
// - Increment extension is bus bit 7 for select 3, source bit 7 for select 2.
// - Constant select 0 gives increment 1; constant select 1 normally gives 2.
// - Constant select 1 withholds 2 under fp condition without fp increment request.
// - Floating-point condition is active whenever the bus condition field equals 4.
// - Constant select 2 gives 1 or 2 from exclusive source-constant decodes.
// - Constant select 3 gives 1, 2, 4 or 10 octal from destination decodes.
// - Constant select 0 routes start vector bits 7:2 through the vector mux.
// - Start vector bit 7 jumper extends into high bits except bits 8 and 11.
// - A trap with no specific condition decoded yields trap vector 4.
// - Emulator-trap and trap instruction vectors are presented at half value.
// - Word offset from bus bits 5:0 shifted left one, always positive.
// - Branch offset from bus bits 7:0 shifted left one, sign-extended from bit 7.
`ifndef ALUIM_DEFINES_VH
`define ALUIM_DEFINES_VH

// ---------------------------------------------------------------------------
// Operand select encodings
// ---------------------------------------------------------------------------
`define ALUIM_ASEL_DST 2'h0
`define ALUIM_ASEL_SRC 2'h1
`define ALUIM_ASEL_PCB 2'h2
`define ALUIM_ASEL_BUS 2'h3
`define ALUIM_BSEL_INC 2'h0
`define ALUIM_BSEL_VEC 2'h1
`define ALUIM_BSEL_SRC 2'h2
`define ALUIM_BSEL_BUS 2'h3
`define ALUIM_KSEL_0 2'h0
`define ALUIM_KSEL_1 2'h1
`define ALUIM_KSEL_2 2'h2
`define ALUIM_KSEL_3 2'h3
`define ALUIM_FUNC_INSTR_DEP 3'h7
`define ALUIM_BUS_COND_FP 3'h4

// ---------------------------------------------------------------------------
// Constant values
// ---------------------------------------------------------------------------
`define ALUIM_INC_ONE 4'h1
`define ALUIM_INC_TWO 4'h2
`define ALUIM_INC_FOUR 4'h4
`define ALUIM_INC_EIGHT 4'h8
`define ALUIM_INC_NONE 4'h0
`define ALUIM_TRAP_DEFAULT 8'h04

// ---------------------------------------------------------------------------
// Register map, field positions and reset values
// ---------------------------------------------------------------------------
`define ALUIM_ADDR_W 8
`define ALUIM_OFS_SV_CFG 8'h00
`define ALUIM_OFS_A_STAT 8'h04
`define ALUIM_OFS_B_STAT 8'h08
`define ALUIM_OFS_FLAGS 8'h0C
`define ALUIM_SV_CFG_MSB 5
`define ALUIM_SV_CFG_RESET 6'h00
`define ALUIM_FLAG_FP_BIT 0
`define ALUIM_FLAG_SGNEX_BIT 1
`define ALUIM_RESP_OKAY 2'h0
`define ALUIM_RESP_SLVERR 2'h2

`endif

// file: verilog/aluim_axil_port.v
// AXI4-Lite slave handshake for the operand selection block.
// Assumes the parent decodes addresses combinationally and answers mapped or not.
`timescale 1ns/1ps
`include "aluim_defines.vh"

module aluim_axil_port (
  input wire clk,
  input wire arst_n,
  input wire [`ALUIM_ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [`ALUIM_ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  output wire wr_en,
  output wire [`ALUIM_ADDR_W-1:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0] wr_strb,
  input wire wr_ok,
  output wire [`ALUIM_ADDR_W-1:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_ok
);

  reg aw_got_ff;
  reg w_got_ff;
  reg [`ALUIM_ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rdata_ff;

  // Address and data are taken in either order; no new write until the response leaves.
  assign awready = !aw_got_ff && !bvalid_ff;
  assign wready = !w_got_ff && !bvalid_ff;
  assign wr_en = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = !rvalid_ff;
  assign rd_addr = araddr;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;

  // ---------------------------------------------------------------------------
  // Write channels
  // ---------------------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= {`ALUIM_ADDR_W{1'b0}};
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `ALUIM_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_en) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `ALUIM_RESP_OKAY : `ALUIM_RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read channels
  // ---------------------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `ALUIM_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_ok ? `ALUIM_RESP_OKAY : `ALUIM_RESP_SLVERR;
      rdata_ff <= rd_ok ? rd_data : 32'h00000000;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// file: verilog/aluim_top.v
// ALU operand input selection: A and B multiplexers, constant generators and
// byte sign extension, with a small AXI4-Lite register port.
// Assumes microprogram fields and decode qualifiers are synchronous to CLK.
`timescale 1ns/1ps
`include "aluim_defines.vh"

module aluim_top (
  input wire CLK,
  input wire ARST_N,
  input wire [1:0] A_SELECT_FIELD,
  input wire [1:0] B_SELECT_FIELD,
  input wire [1:0] CONSTANT_SELECT_FIELD,
  input wire [2:0] ALU_FUNCTION_FIELD,
  input wire [2:0] BUS_CONDITION_FIELD,
  input wire BYTE_MOVE_INSTRUCTION,
  input wire FP_ADDR_INC_REQ,
  input wire [1:0] SOURCE_CONSTANT_SELECT,
  input wire [3:0] DESTINATION_CONSTANT_SELECT,
  input wire TRAP_ACTIVE,
  input wire TRAP_SPECIFIC_VALID,
  input wire [7:0] TRAP_SPECIFIC_VECTOR,
  input wire TRAP_HALVED,
  input wire [15:0] DESTINATION_REGISTER,
  input wire [15:0] SOURCE_REGISTER,
  input wire [15:0] PC_BUFFER,
  input wire [15:0] BUS_REGISTER,
  output wire [15:0] A_OPERAND,
  output wire [15:0] B_OPERAND,
  output wire FP_CONDITION,
  input wire [`ALUIM_ADDR_W-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [`ALUIM_ADDR_W-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);

  reg [`ALUIM_SV_CFG_MSB:0] sv_cfg_ff;
  reg [15:0] a_operand_ff;
  reg [15:0] b_operand_ff;
  reg fp_condition_ff;
  reg sgnex_ff;
  reg [15:0] nxt_a_operand;
  reg [15:0] nxt_b_operand;
  reg [3:0] increment_constant_mux;
  reg [7:1] vector_offset_mux;
  reg vector_extension_bit;
  reg increment_extension_bit;
  reg [7:0] trap_vector;
  reg [7:0] trap_full;
  reg [31:0] rd_data;
  reg rd_ok;
  reg wr_ok;
  wire fp_condition;
  wire byte_move_sign_extend;
  wire [7:2] start_vector;
  wire [15:8] b_high;
  wire wr_en;
  wire [`ALUIM_ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [`ALUIM_ADDR_W-1:0] rd_addr;

  assign A_OPERAND = a_operand_ff;
  assign B_OPERAND = b_operand_ff;
  assign FP_CONDITION = fp_condition_ff;
  assign start_vector = sv_cfg_ff;

  // ---------------------------------------------------------------------------
  // Qualifiers
  // ---------------------------------------------------------------------------
  assign fp_condition = (BUS_CONDITION_FIELD == `ALUIM_BUS_COND_FP);
  assign byte_move_sign_extend = (ALU_FUNCTION_FIELD == `ALUIM_FUNC_INSTR_DEP) &&
    BYTE_MOVE_INSTRUCTION;

  // The extension bit follows the operand being sign-extended.
  always @* begin
    if (B_SELECT_FIELD == `ALUIM_BSEL_BUS) begin
      increment_extension_bit = BUS_REGISTER[7];
    end else if (B_SELECT_FIELD == `ALUIM_BSEL_SRC) begin
      increment_extension_bit = SOURCE_REGISTER[7];
    end else begin
      increment_extension_bit = 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Increment constant generator
  // ---------------------------------------------------------------------------
  always @* begin
    case (CONSTANT_SELECT_FIELD)
      `ALUIM_KSEL_0: begin
        increment_constant_mux = `ALUIM_INC_ONE;
      end
      `ALUIM_KSEL_1: begin
        if (fp_condition && !FP_ADDR_INC_REQ) begin
          increment_constant_mux = `ALUIM_INC_NONE;
        end else begin
          increment_constant_mux = `ALUIM_INC_TWO;
        end
      end
      `ALUIM_KSEL_2: begin
        if (SOURCE_CONSTANT_SELECT[0]) begin
          increment_constant_mux = `ALUIM_INC_ONE;
        end else if (SOURCE_CONSTANT_SELECT[1]) begin
          increment_constant_mux = `ALUIM_INC_TWO;
        end else begin
          increment_constant_mux = `ALUIM_INC_NONE;
        end
      end
      default: begin
        if (DESTINATION_CONSTANT_SELECT[0]) begin
          increment_constant_mux = `ALUIM_INC_ONE;
        end else if (DESTINATION_CONSTANT_SELECT[1]) begin
          increment_constant_mux = `ALUIM_INC_TWO;
        end else if (DESTINATION_CONSTANT_SELECT[2]) begin
          increment_constant_mux = `ALUIM_INC_FOUR;
        end else if (DESTINATION_CONSTANT_SELECT[3]) begin
          increment_constant_mux = `ALUIM_INC_EIGHT;
        end else begin
          increment_constant_mux = `ALUIM_INC_NONE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Trap vector
  // ---------------------------------------------------------------------------
  // Halved vectors are shifted back up by the shared trap microcode.
  always @* begin
    if (TRAP_ACTIVE && TRAP_SPECIFIC_VALID) begin
      trap_full = TRAP_SPECIFIC_VECTOR;
    end else if (TRAP_ACTIVE) begin
      trap_full = `ALUIM_TRAP_DEFAULT;
    end else begin
      trap_full = 8'h00;
    end
    if (TRAP_HALVED) begin
      trap_vector = {1'b0, trap_full[7:1]};
    end else begin
      trap_vector = trap_full;
    end
  end

  // ---------------------------------------------------------------------------
  // Vector and offset generator
  // ---------------------------------------------------------------------------
  always @* begin
    case (CONSTANT_SELECT_FIELD)
      `ALUIM_KSEL_0: begin
        vector_offset_mux = {start_vector[7:2], 1'b0};
        vector_extension_bit = start_vector[7];
      end
      `ALUIM_KSEL_1: begin
        vector_offset_mux = trap_vector[7:1];
        vector_extension_bit = 1'b0;
      end
      `ALUIM_KSEL_2: begin
        vector_offset_mux = {1'b0, BUS_REGISTER[5:0]};
        vector_extension_bit = 1'b0;
      end
      default: begin
        vector_offset_mux = BUS_REGISTER[6:0];
        vector_extension_bit = BUS_REGISTER[7];
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // B operand high byte, one selector per bit
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 8; gi < 16; gi = gi + 1) begin : g_bhi
      // Bits 8 and 11 stay clear for the start vector so its high range skips them.
      wire gated = (gi == 8) || (gi == 11);
      wire vec_bit = gated ? (vector_extension_bit & CONSTANT_SELECT_FIELD[0]) :
        vector_extension_bit;
      assign b_high[gi] = byte_move_sign_extend ? increment_extension_bit :
        (B_SELECT_FIELD == `ALUIM_BSEL_INC) ? increment_extension_bit :
        (B_SELECT_FIELD == `ALUIM_BSEL_VEC) ? vec_bit :
        (B_SELECT_FIELD == `ALUIM_BSEL_SRC) ? SOURCE_REGISTER[gi] : BUS_REGISTER[gi];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // A and B operand multiplexers
  // ---------------------------------------------------------------------------
  always @* begin
    case (A_SELECT_FIELD)
      `ALUIM_ASEL_DST: nxt_a_operand = DESTINATION_REGISTER;
      `ALUIM_ASEL_SRC: nxt_a_operand = SOURCE_REGISTER;
      `ALUIM_ASEL_PCB: nxt_a_operand = PC_BUFFER;
      default: nxt_a_operand = BUS_REGISTER;
    endcase
  end

  always @* begin
    case (B_SELECT_FIELD)
      `ALUIM_BSEL_INC: begin
        nxt_b_operand = {b_high, 4'h0, increment_constant_mux};
      end
      `ALUIM_BSEL_VEC: begin
        nxt_b_operand = {b_high, vector_offset_mux, 1'b0};
      end
      `ALUIM_BSEL_SRC: begin
        nxt_b_operand = {b_high, SOURCE_REGISTER[7:0]};
      end
      default: begin
        nxt_b_operand = {b_high, BUS_REGISTER[7:0]};
      end
    endcase
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_operand_ff <= 16'h0000;
      b_operand_ff <= 16'h0000;
      fp_condition_ff <= 1'b0;
      sgnex_ff <= 1'b0;
    end else begin
      a_operand_ff <= nxt_a_operand;
      b_operand_ff <= nxt_b_operand;
      fp_condition_ff <= fp_condition;
      sgnex_ff <= byte_move_sign_extend;
    end
  end

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  always @* begin
    wr_ok = (wr_addr == `ALUIM_OFS_SV_CFG);
  end

  always @* begin
    rd_ok = 1'b1;
    rd_data = 32'h00000000;
    if (rd_addr == `ALUIM_OFS_SV_CFG) begin
      rd_data[`ALUIM_SV_CFG_MSB:0] = sv_cfg_ff;
    end else if (rd_addr == `ALUIM_OFS_A_STAT) begin
      rd_data[15:0] = a_operand_ff;
    end else if (rd_addr == `ALUIM_OFS_B_STAT) begin
      rd_data[15:0] = b_operand_ff;
    end else if (rd_addr == `ALUIM_OFS_FLAGS) begin
      rd_data[`ALUIM_FLAG_FP_BIT] = fp_condition_ff;
      rd_data[`ALUIM_FLAG_SGNEX_BIT] = sgnex_ff;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // The start vector jumpers live in a writable byte; bit 5 is the range jumper.
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sv_cfg_ff <= `ALUIM_SV_CFG_RESET;
    end else if (wr_en && wr_ok && wr_strb[0]) begin
      sv_cfg_ff <= wr_data[`ALUIM_SV_CFG_MSB:0];
    end
  end

  aluim_axil_port u_port (
    .clk(CLK),
    .arst_n(ARST_N),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

endmodule

// file: tb/aluim_assertions.sv
// Checker for the operand selection datapath, bound to aluim_top.
// Assumes operands and the fp condition follow the inputs one clock later.
`timescale 1ns/1ps

module aluim_assertions (
  input wire CLK,
  input wire ARST_N,
  input wire [1:0] A_SELECT_FIELD,
  input wire [1:0] B_SELECT_FIELD,
  input wire [1:0] CONSTANT_SELECT_FIELD,
  input wire [2:0] ALU_FUNCTION_FIELD,
  input wire [2:0] BUS_CONDITION_FIELD,
  input wire BYTE_MOVE_INSTRUCTION,
  input wire FP_ADDR_INC_REQ,
  input wire [15:0] DESTINATION_REGISTER,
  input wire [15:0] SOURCE_REGISTER,
  input wire [15:0] PC_BUFFER,
  input wire [15:0] BUS_REGISTER,
  input wire [15:0] A_OPERAND,
  input wire [15:0] B_OPERAND,
  input wire FP_CONDITION
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  reg [15:0] a_pick;
  wire sgn = (ALU_FUNCTION_FIELD == 3'h7) && BYTE_MOVE_INSTRUCTION;
  wire [3:0] bk = {B_SELECT_FIELD, CONSTANT_SELECT_FIELD};

  always @* begin
    case (A_SELECT_FIELD)
      2'h0: a_pick = DESTINATION_REGISTER;
      2'h1: a_pick = SOURCE_REGISTER;
      2'h2: a_pick = PC_BUFFER;
      default: a_pick = BUS_REGISTER;
    endcase
  end

  a_amux_route:
    assert property ($past(ARST_N) |-> A_OPERAND == $past(a_pick))
    else $error("A operand differs from the selected register");
  a_breg_route:
    assert property ($past(ARST_N) && $past(B_SELECT_FIELD[1]) && !$past(sgn) |->
      B_OPERAND == ($past(B_SELECT_FIELD[0]) ? $past(BUS_REGISTER) : $past(SOURCE_REGISTER)))
    else $error("B operand differs from the selected register");
  a_inc_high:
    assert property ($past(ARST_N) && $past(B_SELECT_FIELD) == 2'h0 |->
      B_OPERAND[15:4] == 12'h000)
    else $error("Increment path upper bits not zero");
  a_const_one:
    assert property ($past(ARST_N) && $past(bk) == 4'h0 |-> B_OPERAND[3:0] == 4'h1)
    else $error("Increment constant is not one");
  a_fp_withhold:
    assert property ($past(ARST_N) && $past(bk) == 4'h1 && $past(BUS_CONDITION_FIELD) == 3'h4
      && !$past(FP_ADDR_INC_REQ) |-> B_OPERAND[3:0] != 4'h2)
    else $error("Constant two produced under fp condition");
  a_fp_cond:
    assert property ($past(ARST_N) |-> FP_CONDITION == ($past(BUS_CONDITION_FIELD) == 3'h4))
    else $error("Fp condition does not follow the bus condition field");
  a_vec_gated:
    assert property ($past(ARST_N) && $past(B_SELECT_FIELD) == 2'h1
      && !$past(CONSTANT_SELECT_FIELD[0]) |-> !B_OPERAND[0] && !B_OPERAND[8] && !B_OPERAND[11])
    else $error("Vector path gated bits not zero");
  a_word_ofs:
    assert property ($past(ARST_N) && $past(bk) == 4'h6 |->
      B_OPERAND == {9'h000, $past(BUS_REGISTER[5:0]), 1'b0})
    else $error("Word offset wrong");
  a_branch_ofs:
    assert property ($past(ARST_N) && $past(bk) == 4'h7 && !$past(sgn) |->
      B_OPERAND == {{7{$past(BUS_REGISTER[7])}}, $past(BUS_REGISTER[7:0]), 1'b0})
    else $error("Branch offset wrong");
  a_byte_extend:
    assert property ($past(ARST_N) && $past(sgn) && $past(B_SELECT_FIELD[1]) |->
      B_OPERAND[15:8] == {8{$past(B_SELECT_FIELD[0]) ? $past(BUS_REGISTER[7])
      : $past(SOURCE_REGISTER[7])}})
    else $error("Byte move high byte not sign extended");

  c_sign_ext: cover property (sgn && B_SELECT_FIELD == 2'h3);
  c_branch: cover property (bk == 4'h7);
  c_fp: cover property (FP_CONDITION);
endmodule

bind aluim_top aluim_assertions u_chk (.CLK, .ARST_N, .A_SELECT_FIELD, .B_SELECT_FIELD,
  .CONSTANT_SELECT_FIELD, .ALU_FUNCTION_FIELD, .BUS_CONDITION_FIELD, .BYTE_MOVE_INSTRUCTION,
  .FP_ADDR_INC_REQ, .DESTINATION_REGISTER, .SOURCE_REGISTER, .PC_BUFFER, .BUS_REGISTER,
  .A_OPERAND, .B_OPERAND, .FP_CONDITION);

// file: tb/aluim_ucode_model.sv
// Stand-in for the microprogram store and instruction decode logic.
// Assumes the bench calls its tasks; each change lands right after a rising edge.
`timescale 1ns/1ps

module aluim_ucode_model (
  input wire clk
);
  reg [1:0] asel = 2'h0;
  reg [1:0] bsel = 2'h0;
  reg [1:0] ksel = 2'h0;
  reg [2:0] fn = 3'h0;
  reg [2:0] bc = 3'h0;
  reg mb = 1'b0;
  reg inc = 1'b0;
  reg [1:0] sc = 2'h0;
  reg [3:0] dc = 4'h0;
  reg ta = 1'b0;
  reg ts = 1'b0;
  reg [7:0] tv = 8'h00;
  reg th = 1'b0;
  reg [15:0] dr = 16'h0000;
  reg [15:0] sr = 16'h0000;
  reg [15:0] pc = 16'h0000;
  reg [15:0] br = 16'h0000;

  task op(input [1:0] a, b, k, input [2:0] f, c, input m, i);
    begin
      @(posedge clk);
      asel <= a;
      bsel <= b;
      ksel <= k;
      fn <= f;
      bc <= c;
      mb <= m;
      inc <= i;
    end
  endtask

  // Decode qualifiers: source and destination constants, trap state.
  task dec(input [1:0] s, input [3:0] d, input a, v, input [7:0] t, input h);
    begin
      @(posedge clk);
      sc <= s;
      dc <= d;
      ta <= a;
      ts <= v;
      tv <= t;
      th <= h;
    end
  endtask

  task regs(input [15:0] d, s, p, b);
    begin
      @(posedge clk);
      dr <= d;
      sr <= s;
      pc <= p;
      br <= b;
    end
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the ALU operand selection block and its register port.
// Assumes the model drives the datapath side and the bench is AXI4-Lite master.
`timescale 1ns/1ps
`include "aluim_defines.vh"

module tb;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire [15:0] a_op, b_op;
  wire fp_cond, awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [5:0] sv = 6'h00;
  reg [1:0] resp;
  reg [31:0] rd;
  integer miscompares = 0, cmp_count = 0, cycles = 0, i;

  initial forever #2 clk = ~clk;

  aluim_ucode_model ucm (.clk(clk));

  aluim_top dut (
    .CLK(clk), .ARST_N(arst_n), .A_SELECT_FIELD(ucm.asel), .B_SELECT_FIELD(ucm.bsel),
    .CONSTANT_SELECT_FIELD(ucm.ksel), .ALU_FUNCTION_FIELD(ucm.fn),
    .BUS_CONDITION_FIELD(ucm.bc), .BYTE_MOVE_INSTRUCTION(ucm.mb), .FP_ADDR_INC_REQ(ucm.inc),
    .SOURCE_CONSTANT_SELECT(ucm.sc), .DESTINATION_CONSTANT_SELECT(ucm.dc),
    .TRAP_ACTIVE(ucm.ta), .TRAP_SPECIFIC_VALID(ucm.ts), .TRAP_SPECIFIC_VECTOR(ucm.tv),
    .TRAP_HALVED(ucm.th), .DESTINATION_REGISTER(ucm.dr), .SOURCE_REGISTER(ucm.sr),
    .PC_BUFFER(ucm.pc), .BUS_REGISTER(ucm.br), .A_OPERAND(a_op), .B_OPERAND(b_op),
    .FP_CONDITION(fp_cond), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  // ----------------------------------------
  // Checking and reporting
  // ----------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  // Handshakes are judged at the falling edge, where the ready levels are settled.
  task axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
    reg ta, tw, hb;
    integer n;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 20; n = n + 1) begin
        @(negedge clk);
        ta = awvalid & awready;
        tw = wvalid & wready;
        hb = bvalid;
        r = bresp;
        @(posedge clk);
        if (ta)
          awvalid <= 1'b0;
        if (tw)
          wvalid <= 1'b0;
        if (hb) begin
          bready <= 1'b0;
          n = 20;
        end
      end
      if (n == 20)
        chk(32'h0, 32'h1);
    end
  endtask

  task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ta, hr;
    integer n;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 20; n = n + 1) begin
        @(negedge clk);
        ta = arvalid & arready;
        hr = rvalid;
        d = rdata;
        r = rresp;
        @(posedge clk);
        if (ta)
          arvalid <= 1'b0;
        if (hr) begin
          rready <= 1'b0;
          n = 20;
        end
      end
      if (n == 20)
        chk(32'h0, 32'h1);
    end
  endtask

  // ----------------------------------------
  // Expected B operand
  // ----------------------------------------
  function automatic [15:0] e_b();
    reg [3:0] k;
    reg [7:0] v, t;
    reg x, ix;
    begin
      case (ucm.ksel)
        2'h0: k = 4'h1;
        2'h1: k = (ucm.bc == 3'h4 && !ucm.inc) ? 4'h0 : 4'h2;
        2'h2: k = ucm.sc[0] ? 4'h1 : ucm.sc[1] ? 4'h2 : 4'h0;
        default: k = ucm.dc[0] ? 4'h1 : ucm.dc[1] ? 4'h2 : ucm.dc[2] ? 4'h4 : ucm.dc[3] ? 4'h8 : 4'h0;
      endcase
      t = !ucm.ta ? 8'h00 : ucm.ts ? ucm.tv : 8'h04;
      if (ucm.th)
        t = t >> 1;
      x = 1'b0;
      case (ucm.ksel)
        2'h0: {x, v} = {sv[5], sv, 2'b00};
        2'h1: v = t;
        2'h2: v = {1'b0, ucm.br[5:0], 1'b0};
        default: {x, v} = {ucm.br[7], ucm.br[6:0], 1'b0};
      endcase
      ix = ucm.bsel == 2'h3 ? ucm.br[7] : ucm.bsel == 2'h2 ? ucm.sr[7] : 1'b0;
      case (ucm.bsel)
        2'h0: e_b = {8'h00, 4'h0, k};
        2'h1: e_b = {{4{x}}, x & ucm.ksel[0], x, x, x & ucm.ksel[0], v[7:1], 1'b0};
        2'h2: e_b = ucm.sr;
        default: e_b = ucm.br;
      endcase
      if (ucm.fn == 3'h7 && ucm.mb)
        e_b[15:8] = {8{ix}};
    end
  endfunction

  task run(input [1:0] a, b, k, input [2:0] f, c, input m, x);
    begin
      ucm.op(a, b, k, f, c, m, x);
      @(posedge clk);
      #1;
      chk(a_op, a == 2'h0 ? ucm.dr : a == 2'h1 ? ucm.sr : a == 2'h2 ? ucm.pc : ucm.br);
      chk(b_op, e_b());
      chk(fp_cond, c == 3'h4);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    axi_rd(`ALUIM_OFS_SV_CFG, rd, resp);
    chk(rd, 32'h0);
    axi_rd(8'h10, rd, resp);
    chk(resp, `ALUIM_RESP_SLVERR);
    axi_wr(`ALUIM_OFS_A_STAT, 32'h1, resp);
    chk(resp, `ALUIM_RESP_SLVERR);
    ucm.regs(16'h1D2E, 16'h4C93, 16'h0F40, 16'h7AF3);
    for (i = 0; i < 4; i = i + 1)
      run(i[1:0], 2'h2, 2'h0, 3'h0, 3'h0, 1'b0, 1'b0);
    run(0, 3, 0, 7, 0, 1, 0);
    run(0, 2, 0, 7, 0, 1, 0);
    axi_rd(`ALUIM_OFS_FLAGS, rd, resp);
    chk(rd, 32'h2);
    run(0, 3, 0, 6, 0, 1, 0);
    run(0, 0, 0, 7, 0, 1, 0);
    run(0, 0, 1, 0, 0, 0, 0);
    run(0, 0, 1, 0, 4, 0, 0);
    run(0, 0, 1, 0, 4, 0, 1);
    axi_rd(`ALUIM_OFS_FLAGS, rd, resp);
    chk(rd, 32'h1);
    axi_rd(`ALUIM_OFS_B_STAT, rd, resp);
    chk(rd, 32'h2);
    for (i = 1; i < 3; i = i + 1) begin
      ucm.dec(i[1:0], 4'h0, 1'b0, 1'b0, 8'h00, 1'b0);
      run(0, 0, 2, 0, 0, 0, 0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      ucm.dec(2'h0, 4'h1 << i, 1'b0, 1'b0, 8'h00, 1'b0);
      run(0, 0, 3, 0, 0, 0, 0);
    end
    axi_wr(`ALUIM_OFS_SV_CFG, 32'hFFFFFFFF, resp);
    sv = 6'h3F;
    axi_rd(`ALUIM_OFS_SV_CFG, rd, resp);
    chk(rd, 32'h3F);
    run(0, 1, 0, 0, 0, 0, 0);
    axi_wr(`ALUIM_OFS_SV_CFG, 32'h1F, resp);
    sv = 6'h1F;
    run(0, 1, 0, 0, 0, 0, 0);
    ucm.dec(2'h0, 4'h0, 1'b1, 1'b0, 8'h00, 1'b0);
    run(0, 1, 1, 0, 0, 0, 0);
    ucm.dec(2'h0, 4'h0, 1'b1, 1'b1, 8'h30, 1'b1);
    run(0, 1, 1, 0, 0, 0, 0);
    run(0, 1, 2, 0, 0, 0, 0);
    run(0, 1, 3, 0, 0, 0, 0);
    ucm.regs(16'h1D2E, 16'h4C93, 16'h0F40, 16'h8A05);
    run(0, 1, 2, 0, 0, 0, 0);
    run(0, 1, 3, 0, 0, 0, 0);
    wrap_up;
  end
endmodule
